// [src/fls_sequencer.sv]
`timescale 1ns/1ps
module fls_sequencer import fls_pkg::*; #(
  parameter int ACC_W = 27,
  parameter int SAMPLE_W = 20
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [15:0] reg_rdata,
  input wire logic slot_start,
  input wire logic slot_b,
  input wire logic signed [SAMPLE_W-1:0] afe_result,
  output fls_win_t win_o,
  output logic busy,
  output logic out_valid,
  output logic signed [ACC_W-1:0] out_data
);

  function automatic logic [3:0] reg_index(input logic [7:0] addr);
    reg_index = 4'(REG_N);
    for (int i = 0; i < REG_N; i++) begin
      if (REG_ADDRS[i] == addr) begin
        reg_index = 4'(i);
      end
    end
  endfunction : reg_index

  function automatic logic [TIME_W-1:0] to_ticks(input logic [9:0] us);
    to_ticks = TIME_W'(us) * TIME_W'(TICKS_PER_US);
  endfunction : to_ticks

  // Returns {used, subtract} for a position within the group of four
  function automatic logic [1:0] pulse_op(input logic [1:0] pair1, input logic [1:0] pair2,
                                          input logic [1:0] pos);
    logic [1:0] field;
    field = pos[1] ? pair2 : pair1;
    unique case (field)
      SIGN_SUB_ADD: pulse_op = {1'b1, !pos[0]};
      SIGN_ADD_SUB: pulse_op = {1'b1, pos[0]};
      default: pulse_op = 2'b00;
    endcase
  endfunction : pulse_op

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [15:0] regs_q [REG_N];
  logic [3:0] widx;
  fls_state_t state_q;
  logic [1:0] pos_q;
  logic [7:0] idx_q;

  assign widx = reg_index(reg_addr);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int i = 0; i < REG_N; i++) begin
        regs_q[i] <= REG_RESET;
      end
    end else if (reg_we && widx != 4'(REG_N)) begin
      regs_q[widx] <= reg_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_re) begin
      if (widx != 4'(REG_N)) begin
        reg_rdata <= regs_q[widx];
      end else if (reg_addr == ADDR_STATUS) begin
        reg_rdata <= {5'h00, state_q != ST_IDLE, pos_q, idx_q};
      end else begin
        reg_rdata <= 16'h0000;
      end
    end
  end

  function automatic logic [15:0] rv(input logic [7:0] addr);
    rv = regs_q[reg_index(addr)];
  endfunction : rv

  ////////////////////////////////////////////////////////////////////////////
  // Slot configuration, latched at sample start
  fls_cfg_t cfg_d;
  fls_cfg_t cfg_q;
  logic [1:0] route;
  logic [9:0] dump_sum;
  logic [15:0] dump_r;
  logic [15:0] period_r;
  logic [15:0] route_r, precon_r, fhi_r, integ_r, flash_r, fire_r, sign_r;

  always_comb begin
    dump_r = rv(slot_b ? ADDR_DUMP_B : ADDR_DUMP_A);
    period_r = rv(slot_b ? ADDR_PERIOD_B : ADDR_PERIOD_A);
    route_r = rv(ADDR_ROUTE_SEL);
    precon_r = rv(slot_b ? ADDR_PRECON_B : ADDR_PRECON_A);
    fhi_r = rv(ADDR_FLOAT_HI);
    integ_r = rv(slot_b ? ADDR_INTEG_B : ADDR_INTEG_A);
    flash_r = rv(slot_b ? ADDR_FLASH_B : ADDR_FLASH_A);
    fire_r = rv(ADDR_FIRE);
    sign_r = rv(ADDR_SIGN);
    route = route_r[(slot_b ? ROUTE_B_LSB : ROUTE_A_LSB) +: 2];
    cfg_d.precon = precon_r[PRECON_LSB +: 5];
    cfg_d.connect = dump_r[CONNECT_LSB +: 5];
    cfg_d.float2 = {fhi_r[(slot_b ? FLOAT_HI_B_LSB : FLOAT_HI_A_LSB) +: 2],
                    period_r[FLOAT_LO_LSB +: 8]};
    // Derived, so the first dump lands at the programmed time; clamped at zero
    dump_sum = 10'(dump_r[FIRST_DUMP_LSB +: 8]) + 10'(cfg_d.connect);
    cfg_d.float1 = (dump_sum > 10'(cfg_d.precon)) ? dump_sum - 10'(cfg_d.precon) : 10'h000;
    cfg_d.integ_start = integ_r[INTEG_START_LSB +: 11];
    cfg_d.integ_width = integ_r[INTEG_WIDTH_LSB +: 5];
    cfg_d.flash_start = flash_r[FLASH_START_LSB +: 8];
    cfg_d.flash_width = flash_r[FLASH_WIDTH_LSB +: 5];
    cfg_d.mask = fire_r[(slot_b ? MASK_B_LSB : MASK_A_LSB) +: 4];
    cfg_d.pair1 = sign_r[(slot_b ? PAIR1_B_LSB : PAIR1_A_LSB) +: 2];
    cfg_d.pair2 = sign_r[(slot_b ? PAIR2_B_LSB : PAIR2_A_LSB) +: 2];
    cfg_d.pulses = period_r[PULSE_CNT_LSB +: 8];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timebase: 31.25 ns ticks from a 10 ns clock by phase accumulation
  logic [15:0] phase_q;
  logic [15:0] phase_sum;
  logic tick;

  assign phase_sum = phase_q + 16'(CLK_PS);
  assign tick = phase_sum >= 16'(TICK_PS);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      phase_q <= 16'h0000;
    end else begin
      phase_q <= tick ? phase_sum - 16'(TICK_PS) : phase_sum;
    end
  end

  tick_gap_a: assert property (@(posedge clock) disable iff (!rst_n) tick |=> !tick [*2])
    else $error("timebase ticks too close");

  ////////////////////////////////////////////////////////////////////////////
  // Pulse windows
  logic [TIME_W-1:0] tcnt_q;
  logic [TIME_W-1:0] pre_end, flt_end, pulse_end, fl_beg, fl_end, ib, ie, nb, ne, iw;
  logic [TIME_W-1:0] ct, dump_beg;
  logic start_ok, pulse_done, last_pulse;
  fls_win_t win_d;

  assign start_ok = slot_start && state_q == ST_IDLE && route == ROUTE_FLOAT;
  assign pulse_done = state_q == ST_RUN && tick && (tcnt_q + 16'h0001 >= pulse_end);
  assign last_pulse = idx_q + 8'h01 >= cfg_q.pulses;

  always_comb begin
    pre_end = to_ticks(10'(cfg_q.precon));
    flt_end = pre_end + to_ticks(idx_q == 8'h00 ? cfg_q.float1 : cfg_q.float2);
    // Dump takes the tail of the float interval, so on the first pulse it starts at the first-dump time
    ct = to_ticks(10'(cfg_q.connect));
    dump_beg = (flt_end > ct) ? flt_end - ct : 16'h0000;
    pulse_end = flt_end;
    fl_beg = to_ticks(10'(cfg_q.flash_start));
    fl_end = fl_beg + to_ticks(10'(cfg_q.flash_width));
    iw = to_ticks(10'(cfg_q.integ_width));
    ib = TIME_W'(cfg_q.integ_start) + TIME_W'(INTEG_DELAY_TICKS);
    ie = ib + iw;
    // Middle half of the window is the negative phase, so it straddles the window centre
    nb = ib + (iw >> 2);
    ne = ib + iw - (iw >> 2);
    win_d.precon = tcnt_q < pre_end;
    win_d.flt = tcnt_q >= pre_end && tcnt_q < dump_beg;
    win_d.connect = tcnt_q >= dump_beg && tcnt_q < pulse_end;
    win_d.flash = tcnt_q >= fl_beg && tcnt_q < fl_end && !cfg_q.mask[pos_q];
    win_d.integ = tcnt_q >= ib && tcnt_q < ie;
    win_d.integ_neg = tcnt_q >= nb && tcnt_q < ne;
    if (state_q != ST_RUN) begin
      win_d = '0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      win_o <= '0;
    end else begin
      win_o <= win_d;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tcnt_q <= '0;
    end else if (start_ok || pulse_done) begin
      tcnt_q <= '0;
    end else if (state_q == ST_RUN && tick) begin
      tcnt_q <= tcnt_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequence control
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cfg_q <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start_ok) begin
            state_q <= ST_RUN;
            cfg_q <= cfg_d;
          end
        end
        ST_RUN: begin
          if (pulse_done && last_pulse) begin
            state_q <= ST_FINISH;
          end
        end
        ST_FINISH: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pos_q <= 2'h0;
      idx_q <= 8'h00;
    end else if (start_ok) begin
      pos_q <= 2'h0;
      idx_q <= 8'h00;
    end else if (pulse_done) begin
      pos_q <= pos_q + 2'h1;
      idx_q <= idx_q + 8'h01;
    end
  end

  assign busy = state_q != ST_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // Signed accumulation, one result per sample period
  logic signed [ACC_W-1:0] acc_q;
  logic [1:0] op;

  assign op = pulse_op(cfg_q.pair1, cfg_q.pair2, pos_q);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      acc_q <= '0;
    end else if (start_ok) begin
      acc_q <= '0;
    end else if (pulse_done && op[1]) begin
      acc_q <= op[0] ? acc_q - ACC_W'(afe_result) : acc_q + ACC_W'(afe_result);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      out_valid <= state_q == ST_FINISH;
      if (state_q == ST_FINISH) begin
        out_data <= acc_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  pos_restart_a: assert property (@(posedge clock) disable iff (!rst_n)
    start_ok |=> pos_q == 2'h0 && idx_q == 8'h00 && state_q == ST_RUN)
    else $error("pulse position not restarted");

  group_wrap_a: assert property (@(posedge clock) disable iff (!rst_n)
    pulse_done && pos_q == 2'h3 && !last_pulse |=> pos_q == 2'h0 && state_q == ST_RUN)
    else $error("group of four did not wrap");

  flash_mask_a: assert property (@(posedge clock) disable iff (!rst_n)
    win_o.flash |-> !cfg_q.mask[$past(pos_q)] && $past(tcnt_q) >= to_ticks(10'(cfg_q.flash_start)))
    else $error("flash in masked position");

  first_float_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(win_o.connect) && $past(idx_q) == 8'h00 |->
      $past(tcnt_q) == to_ticks(10'(cfg_q.precon)) + to_ticks(cfg_q.float1) - to_ticks(10'(cfg_q.connect)))
    else $error("first dump misplaced");

  later_float_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(win_o.connect) && $past(idx_q) != 8'h00 |->
      $past(tcnt_q) == to_ticks(10'(cfg_q.precon)) + to_ticks(cfg_q.float2) - to_ticks(10'(cfg_q.connect)))
    else $error("float period not applied");

  integ_delay_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(win_o.integ) |-> $past(tcnt_q) == TIME_W'(cfg_q.integ_start) + TIME_W'(INTEG_DELAY_TICKS))
    else $error("integration start delay wrong");

  sub_first_a: assert property (@(posedge clock) disable iff (!rst_n)
    pulse_done && pos_q == 2'h0 && cfg_q.pair1 == SIGN_SUB_ADD |=>
      acc_q == $past(acc_q) - ACC_W'($past(afe_result)))
    else $error("first pulse not subtracted");

  add_third_a: assert property (@(posedge clock) disable iff (!rst_n)
    pulse_done && pos_q == 2'h2 && cfg_q.pair2 == SIGN_ADD_SUB |=>
      acc_q == $past(acc_q) + ACC_W'($past(afe_result)))
    else $error("third pulse not added");

  final_write_a: assert property (@(posedge clock) disable iff (!rst_n)
    pulse_done && last_pulse |=> state_q == ST_FINISH ##1 out_valid && out_data == $past(acc_q))
    else $error("final value not written once");

  route_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
    slot_start && state_q == ST_IDLE && route != ROUTE_FLOAT |=> state_q == ST_IDLE)
    else $error("non-float slot started");

endmodule : fls_sequencer

// [src/fls_pkg.sv]
package fls_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] ADDR_ROUTE_SEL = 8'h14;
  localparam logic [7:0] ADDR_DUMP_A = 8'h30;
  localparam logic [7:0] ADDR_PERIOD_A = 8'h31;
  localparam logic [7:0] ADDR_DUMP_B = 8'h35;
  localparam logic [7:0] ADDR_PERIOD_B = 8'h36;
  localparam logic [7:0] ADDR_FLOAT_HI = 8'h37;
  localparam logic [7:0] ADDR_INTEG_A = 8'h39;
  localparam logic [7:0] ADDR_INTEG_B = 8'h3b;
  localparam logic [7:0] ADDR_FLASH_A = 8'h3e;
  localparam logic [7:0] ADDR_FLASH_B = 8'h3f;
  localparam logic [7:0] ADDR_SIGN = 8'h58;
  localparam logic [7:0] ADDR_PRECON_B = 8'h59;
  localparam logic [7:0] ADDR_FIRE = 8'h5a;
  localparam logic [7:0] ADDR_PRECON_A = 8'h5e;
  localparam logic [7:0] ADDR_STATUS = 8'h70;
  localparam int REG_N = 14;
  localparam logic [7:0] REG_ADDRS [REG_N] = '{ADDR_ROUTE_SEL, ADDR_DUMP_A, ADDR_PERIOD_A, ADDR_DUMP_B,
    ADDR_PERIOD_B, ADDR_FLOAT_HI, ADDR_INTEG_A, ADDR_INTEG_B, ADDR_FLASH_A, ADDR_FLASH_B, ADDR_SIGN,
    ADDR_PRECON_B, ADDR_FIRE, ADDR_PRECON_A};
  localparam logic [15:0] REG_RESET = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int FIRST_DUMP_LSB = 0;
  localparam int CONNECT_LSB = 8;
  localparam int FLOAT_LO_LSB = 0;
  localparam int PULSE_CNT_LSB = 8;
  localparam int FLOAT_HI_A_LSB = 0;
  localparam int FLOAT_HI_B_LSB = 8;
  localparam int INTEG_START_LSB = 0;
  localparam int INTEG_WIDTH_LSB = 11;
  localparam int FLASH_START_LSB = 0;
  localparam int FLASH_WIDTH_LSB = 8;
  localparam int PAIR1_A_LSB = 1;
  localparam int PAIR1_B_LSB = 5;
  localparam int PAIR2_A_LSB = 8;
  localparam int PAIR2_B_LSB = 10;
  localparam int PRECON_LSB = 8;
  localparam int MASK_A_LSB = 8;
  localparam int MASK_B_LSB = 12;
  localparam int ROUTE_A_LSB = 0;
  localparam int ROUTE_B_LSB = 2;

  localparam logic [1:0] ROUTE_FLOAT = 2'h0;
  localparam logic [1:0] SIGN_SUB_ADD = 2'h2;
  localparam logic [1:0] SIGN_ADD_SUB = 2'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Timebase
  localparam int CLK_PS = 10000;
  localparam int TICK_PS = 31250;
  localparam int TICKS_PER_US = 1000000 / TICK_PS;
  localparam int INTEG_DELAY_US = 9;
  localparam int INTEG_DELAY_TICKS = INTEG_DELAY_US * TICKS_PER_US;
  localparam int TIME_W = 16;

  typedef struct packed {
    logic [4:0] precon;
    logic [9:0] float1;
    logic [9:0] float2;
    logic [4:0] connect;
    logic [10:0] integ_start;
    logic [4:0] integ_width;
    logic [7:0] flash_start;
    logic [4:0] flash_width;
    logic [3:0] mask;
    logic [1:0] pair1;
    logic [1:0] pair2;
    logic [7:0] pulses;
  } fls_cfg_t;

  typedef struct packed {
    logic precon;
    logic flt;
    logic connect;
    logic flash;
    logic integ;
    logic integ_neg;
  } fls_win_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_FINISH = 3'b100
  } fls_state_t;

endpackage : fls_pkg

// [verif/fls_afe_model.sv]
`timescale 1ns/1ps
module fls_afe_model import fls_pkg::*; #(
  parameter int LED_GAIN = 37
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire fls_win_t win,
  output logic signed [19:0] afe_result,
  output int flashes,
  output int flash_cyc,
  output int flash_lag,
  output int integ_lag
);
  fls_win_t prev_q;
  int since_q;
  logic [19:0] flt_q;
  logic lit_q;

  ////////////////////////////////////////////////////////////////////////////
  // Charge grows with float time, so a float length error shows in the sum
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prev_q <= '0;
      since_q <= 0;
      flt_q <= 20'h00000;
      lit_q <= 1'h0;
      flashes <= 0;
      flash_cyc <= 0;
      flash_lag <= 0;
      integ_lag <= 0;
    end else begin
      prev_q <= win;
      if (win.precon && !prev_q.precon) begin
        since_q <= 0;
        flt_q <= 20'h00000;
        lit_q <= 1'h0;
      end else begin
        since_q <= since_q + 1;
        if (win.flt) begin
          flt_q <= flt_q + 20'h00001;
        end
        if (win.flash) begin
          lit_q <= 1'h1;
        end
      end
      if (win.flash) begin
        flash_cyc <= flash_cyc + 1;
      end
      if (win.flash && !prev_q.flash) begin
        flashes <= flashes + 1;
        flash_lag <= since_q;
      end
      if (win.integ && !prev_q.integ) begin
        integ_lag <= since_q;
      end
    end
  end

  // Result holds until the next pulse starts
  assign afe_result = $signed(flt_q + (lit_q ? 20'(LED_GAIN) : 20'h00000));
endmodule : fls_afe_model

// [verif/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import fls_pkg::*;
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_we = 1'h0;
  logic reg_re = 1'h0;
  logic [15:0] reg_rdata;
  logic slot_start = 1'h0;
  logic slot_b = 1'h0;
  logic signed [19:0] afe_result;
  fls_win_t win_o;
  logic busy;
  logic out_valid;
  logic signed [26:0] out_data;
  logic signed [26:0] res;
  int miscompares = 0;
  int tests_run = 0;
  int flashes, flash_cyc, flash_lag, integ_lag, f0, c0, n0, k0;
  int neg_cyc = 0;
  int conn_cyc = 0;

  always #5 clock = ~clock;

  // Window lengths as the far side sees them
  always @(posedge clock) begin
    if (win_o.integ_neg === 1'h1) begin
      neg_cyc++;
    end
    if (win_o.connect === 1'h1) begin
      conn_cyc++;
    end
  end

  fls_sequencer fls_sequencer_i (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .slot_start(slot_start), .slot_b(slot_b),
    .afe_result(afe_result), .win_o(win_o), .busy(busy), .out_valid(out_valid), .out_data(out_data));
  fls_afe_model fls_afe_model_i (.clock(clock), .rst_n(rst_n), .win(win_o), .afe_result(afe_result),
    .flashes(flashes), .flash_cyc(flash_cyc), .flash_lag(flash_lag), .integ_lag(integ_lag));

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Tick edges fall on 3 or 4 clocks, so window lengths carry a small slack
  task automatic near(input logic signed [31:0] got, input int exp, input int tol);
    tests_run++;
    if ($isunknown(got) || got > exp + tol || got < exp - tol) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : near

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1'h1;
    @(negedge clock);
    reg_we = 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(negedge clock);
    reg_addr = a;
    reg_re = 1'h1;
    @(negedge clock);
    reg_re = 1'h0;
    check(reg_rdata, exp);
  endtask : rd

  task automatic run(input logic b, output logic signed [26:0] r);
    @(negedge clock);
    slot_start = 1'h1;
    slot_b = b;
    @(negedge clock);
    slot_start = 1'h0;
    check(busy, 1'h1);
    r = 'x;
    for (int i = 0; i < 20000; i++) begin
      @(posedge clock);
      #1;
      if (out_valid === 1'h1) begin
        r = out_data;
        break;
      end
    end
  endtask : run

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(negedge clock);
    rst_n = 1'h1;
    rd(8'h00, 16'h0000);
    for (int i = 0; i < REG_N; i++) rd(REG_ADDRS[i], REG_RESET);
    for (int i = 0; i < REG_N; i++) wr(REG_ADDRS[i], 16'hc3a5 + 16'(i));
    for (int i = 0; i < REG_N; i++) rd(REG_ADDRS[i], 16'hc3a5 + 16'(i));
    wr(ADDR_STATUS, 16'hffff);
    rd(ADDR_STATUS, 16'h0000);
    wr(8'h01, 16'hffff);
    rd(8'h01, 16'h0000);
    for (int i = 0; i < REG_N; i++) wr(REG_ADDRS[i], 16'h0000);
    // Slot B: equal 15 us floats, LED in positions two and three, 8 pulses
    wr(ADDR_DUMP_B, 16'h020e);
    wr(ADDR_PERIOD_B, 16'h080f);
    wr(ADDR_INTEG_B, 16'h1838);
    wr(ADDR_FLASH_B, 16'h0102);
    wr(ADDR_SIGN, 16'h0444);
    wr(ADDR_PRECON_B, 16'h0100);
    wr(ADDR_FIRE, 16'h9f00);
    for (int r = 0; r < 2; r++) begin
      f0 = flashes;
      c0 = flash_cyc;
      n0 = neg_cyc;
      k0 = conn_cyc;
      run(1'h1, res);
      near(res, 4 * 37, 8);
      check(flashes - f0, 4);
      near(flash_cyc - c0, 400, 4);
      near(neg_cyc - n0, 1200, 4);
      near(conn_cyc - k0, 1600, 4);
    end
    near(flash_lag, 200, 2);
    near(integ_lag, 1075, 4);
    // Non-float route must not start
    wr(ADDR_ROUTE_SEL, 16'h0001);
    @(negedge clock);
    slot_start = 1'h1;
    slot_b = 1'h0;
    @(negedge clock);
    slot_start = 1'h0;
    repeat (2) @(negedge clock);
    check(busy, 1'h0);
    wr(ADDR_ROUTE_SEL, 16'h0000);
    // Slot A ambient: float1 4 us, float2 8 us, no flashes
    wr(ADDR_DUMP_A, 16'h0203);
    wr(ADDR_PERIOD_A, 16'h0208);
    wr(ADDR_PRECON_A, 16'h0100);
    wr(ADDR_FLASH_A, 16'h0102);
    f0 = flashes;
    k0 = conn_cyc;
    run(1'h0, res);
    near(res, 400, 4);
    near(conn_cyc - k0, 400, 4);
    check(flashes - f0, 0);
    end_of_test();
  end

  initial begin
    repeat (60000) @(posedge clock);
    miscompares++;
    end_of_test();
  end
endmodule : tb_top
